// >>> verilog/synbc_pkg.sv
// shared constants and types for the synthesizer configuration and band calibration block
`default_nettype none
package synbc_pkg;
  // --------------------------------------------------------------------------
  // serial word layout
  // --------------------------------------------------------------------------
  localparam int WORD_W = 32;
  localparam int ADDR_LSB = 0;
  localparam int ADDR_W = 4;
  localparam logic [3:0] LATCH_LAST = 4'hc;
  localparam logic [3:0] LATCH_R0 = 4'h0;
  localparam logic [3:0] LATCH_R1 = 4'h1;
  localparam logic [3:0] LATCH_R2 = 4'h2;
  localparam logic [3:0] LATCH_R3 = 4'h3;
  localparam logic [3:0] LATCH_R4 = 4'h4;
  localparam logic [3:0] LATCH_R6 = 4'h6;

  // --------------------------------------------------------------------------
  // field positions
  // --------------------------------------------------------------------------
  localparam int R0_INT_LSB = 4;
  localparam int R0_PRESCALER = 20;
  localparam int R0_AUTOCAL = 21;
  localparam int R1_FRAC_LSB = 4;
  localparam int R2_MOD_LSB = 4;
  localparam int R2_FRAC_LSB = 18;
  localparam int R3_PHASE_LSB = 4;
  localparam int R4_CP_LSB = 10;
  localparam int R4_DBUF = 14;
  localparam int R4_RCNT_LSB = 15;
  localparam int R4_HALVE = 25;
  localparam int R4_DOUBLER = 26;
  localparam int R6_PWR_LSB = 4;
  localparam int R6_RF_EN = 6;
  localparam int R6_AUX_PWR_LSB = 7;
  localparam int R6_AUX_EN = 9;
  localparam int R6_MUTE = 11;
  localparam int R6_DIV_LSB = 21;
  localparam int R6_FB_SEL = 24;

  // --------------------------------------------------------------------------
  // calibration search
  // --------------------------------------------------------------------------
  localparam int CORE_W = 2;
  localparam int BAND_W = 8;
  localparam int SEARCH_W = CORE_W + BAND_W;
  localparam logic [7:0] SETTLE_RESET = 8'h04;

  // --------------------------------------------------------------------------
  // wishbone map (byte addresses)
  // --------------------------------------------------------------------------
  localparam logic [3:0] WB_CTRL = 4'h0;
  localparam logic [3:0] WB_STATUS = 4'h4;
  localparam logic [3:0] WB_INT = 4'h8;

  typedef enum logic [2:0] {
    SYNBC_IDLE = 3'b001,
    SYNBC_SETTLE = 3'b010,
    SYNBC_JUDGE = 3'b100
  } synbc_cal_t;

  typedef struct packed {
    logic [23:0] main_fraction;
    logic [13:0] aux_modulus;
    logic [13:0] aux_fraction;
    logic ref_doubler;
    logic ref_halve;
    logic [23:0] phase;
    logic [9:0] ref_count;
    logic [3:0] cp_current;
  } synbc_staged_t;
endpackage : synbc_pkg
`default_nettype wire

// >>> verilog/synbc_shift.sv
// serial shift register running on the host's serial clock
`default_nettype none
module synbc_shift #(
  parameter int WIDTH = 32
) (
  input wire logic sclk_i,
  input wire logic sdata_i,
  output logic [WIDTH-1:0] word_o
);
  initial begin
    if (WIDTH < 5) begin
      $error("synbc_shift: width too small for address field");
    end
  end

  // msb first, one bit per rising serial edge; no reset since this clock
  // only runs inside frames and the word is only used after a load strobe
  always_ff @(posedge sclk_i) begin
    word_o <= {word_o[WIDTH-2:0], sdata_i}; // RQ13
  end
endmodule : synbc_shift
`default_nettype wire

// >>> verilog/synbc_top.sv
// synthesizer control: buffered config latches, band calibration and wishbone status
//
// Behaviour
// RQ1: staged copies hold fraction, modulus, reference, phase, pump
// RQ2: staged values commit only on later register-0 load
// RQ3: divider select staged only when buffering bit set
// RQ4: register-0 load with autocal starts band search
// RQ5: tuning input tied to reference during search
// RQ6: search advances on reference counter output only
// RQ7: tuning reconnects to loop filter after search
// RQ8: search picks one of four cores, 256 bands
// RQ9: two-bit power field selects tail current level
// RQ10: mute bit holds output supply off until lock
// RQ11: three-bit divider field selects output division ratio
// RQ12: secondary output enabled independently of primary
// RQ13: word shifted msb first, latched on strobe rise
// RQ14: low four bits address latch 0 to 12; only latches 0 to 4 and 6 are decoded, all other addresses are dropped
// RQ15: register-0 load without autocal commits, skips search
// RQ16: lock suppressed while band search runs
`default_nettype none
module synbc_top #(
  parameter int WORD_W = synbc_pkg::WORD_W
) (
  input wire logic clk_i,
  input wire logic rst_i,
  // serial programming port
  input wire logic sclk_i,
  input wire logic sdata_i,
  input wire logic load_strobe_i,
  // analog-side status
  input wire logic lock_detect_i,
  input wire logic ref_tick_i,
  input wire logic vco_high_i,
  // wishbone classic slave
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [3:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  // committed settings and controls
  output synbc_pkg::synbc_staged_t active_o,
  output logic [15:0] int_value_o,
  output logic prescaler_o,
  output logic [2:0] div_select_o,
  output logic feedback_select_o,
  output logic [1:0] out_power_o,
  output logic [1:0] aux_power_o,
  output logic primary_supply_o,
  output logic secondary_supply_o,
  output logic tune_to_ref_o,
  output logic cal_busy_o,
  output logic [synbc_pkg::CORE_W-1:0] core_o,
  output logic [synbc_pkg::BAND_W-1:0] band_o,
  output logic lock_o
);
  initial begin
    if (WORD_W != 32) begin
      $error("synbc_top: only 32-bit serial words are supported");
    end
  end

  // --------------------------------------------------------------------------
  // serial link
  // --------------------------------------------------------------------------
  logic [WORD_W-1:0] shift_word;
  logic [WORD_W-1:0] word;
  logic [2:0] le_sync;
  logic [1:0] lock_sync;
  logic [2:0] tick_sync;
  logic [1:0] high_sync;
  logic load;
  logic tick;

  synbc_shift #(
    .WIDTH(WORD_W)
  ) u_shift (
    .sclk_i(sclk_i),
    .sdata_i(sdata_i),
    .word_o(shift_word)
  );

  // the host holds the serial clock still while the strobe is high, so the
  // shifted word is stable when the synchronised strobe edge arrives here
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      le_sync <= 3'h0;
      lock_sync <= 2'h0;
      tick_sync <= 3'h0;
      high_sync <= 2'h0;
    end else begin
      le_sync <= {le_sync[1:0], load_strobe_i};
      lock_sync <= {lock_sync[0], lock_detect_i};
      tick_sync <= {tick_sync[1:0], ref_tick_i};
      high_sync <= {high_sync[0], vco_high_i};
    end
  end

  assign load = le_sync[1] & ~le_sync[2]; // RQ13
  assign tick = tick_sync[1] & ~tick_sync[2]; // RQ6
  assign word = shift_word;

  function automatic logic hit(input logic [WORD_W-1:0] w, input logic [3:0] n);
    hit = (w[synbc_pkg::ADDR_LSB +: synbc_pkg::ADDR_W] == n);
  endfunction : hit

  logic ld_r0;
  logic ld_r1;
  logic ld_r2;
  logic ld_r3;
  logic ld_r4;
  logic ld_r6;

  // addresses above the last latch are dropped
  assign ld_r0 = load & hit(word, synbc_pkg::LATCH_R0); // RQ14
  assign ld_r1 = load & hit(word, synbc_pkg::LATCH_R1); // RQ14
  assign ld_r2 = load & hit(word, synbc_pkg::LATCH_R2); // RQ14
  assign ld_r3 = load & hit(word, synbc_pkg::LATCH_R3); // RQ14
  assign ld_r4 = load & hit(word, synbc_pkg::LATCH_R4); // RQ14
  assign ld_r6 = load & hit(word, synbc_pkg::LATCH_R6); // RQ14

  // --------------------------------------------------------------------------
  // staged latches
  // --------------------------------------------------------------------------
  synbc_pkg::synbc_staged_t staged;
  logic dbuf_div;
  logic [2:0] staged_div;
  logic autocal;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      staged <= '0;
    end else begin
      if (ld_r1) begin
        staged.main_fraction <= word[synbc_pkg::R1_FRAC_LSB +: 24]; // RQ1
      end
      if (ld_r2) begin
        staged.aux_modulus <= word[synbc_pkg::R2_MOD_LSB +: 14]; // RQ1
        staged.aux_fraction <= word[synbc_pkg::R2_FRAC_LSB +: 14]; // RQ1
      end
      if (ld_r3) begin
        staged.phase <= word[synbc_pkg::R3_PHASE_LSB +: 24]; // RQ1
      end
      if (ld_r4) begin
        staged.ref_doubler <= word[synbc_pkg::R4_DOUBLER]; // RQ1
        staged.ref_halve <= word[synbc_pkg::R4_HALVE]; // RQ1
        staged.ref_count <= word[synbc_pkg::R4_RCNT_LSB +: 10]; // RQ1
        staged.cp_current <= word[synbc_pkg::R4_CP_LSB +: 4]; // RQ1
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      dbuf_div <= 1'b0;
      staged_div <= 3'h0;
      autocal <= 1'b0;
    end else begin
      if (ld_r4) begin
        dbuf_div <= word[synbc_pkg::R4_DBUF];
      end
      if (ld_r6) begin
        staged_div <= word[synbc_pkg::R6_DIV_LSB +: 3];
      end
      if (ld_r0) begin
        autocal <= word[synbc_pkg::R0_AUTOCAL];
      end
    end
  end

  // --------------------------------------------------------------------------
  // commit on register 0
  // --------------------------------------------------------------------------
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      active_o <= '0;
      int_value_o <= 16'h0000;
      prescaler_o <= 1'b0;
    end else if (ld_r0) begin
      active_o <= staged; // RQ2 RQ15
      int_value_o <= word[synbc_pkg::R0_INT_LSB +: 16];
      prescaler_o <= word[synbc_pkg::R0_PRESCALER];
    end
  end

  // divider select: immediate unless buffering is enabled in register 4
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      div_select_o <= 3'h0;
    end else if (ld_r6 && !dbuf_div) begin
      div_select_o <= word[synbc_pkg::R6_DIV_LSB +: 3]; // RQ3 RQ11
    end else if (ld_r0 && dbuf_div) begin
      div_select_o <= staged_div; // RQ3 RQ11
    end
  end

  // --------------------------------------------------------------------------
  // output stage controls
  // --------------------------------------------------------------------------
  logic rf_en;
  logic aux_en;
  logic mute_until_locked;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      out_power_o <= 2'h0;
      aux_power_o <= 2'h0;
      feedback_select_o <= 1'b0;
      rf_en <= 1'b0;
      aux_en <= 1'b0;
      mute_until_locked <= 1'b0;
    end else if (ld_r6) begin
      out_power_o <= word[synbc_pkg::R6_PWR_LSB +: 2]; // RQ9
      aux_power_o <= word[synbc_pkg::R6_AUX_PWR_LSB +: 2];
      feedback_select_o <= word[synbc_pkg::R6_FB_SEL]; // RQ11
      rf_en <= word[synbc_pkg::R6_RF_EN]; // RQ12
      aux_en <= word[synbc_pkg::R6_AUX_EN]; // RQ12
      mute_until_locked <= word[synbc_pkg::R6_MUTE];
    end
  end

  // lock is held low through calibration so the mute also covers the search
  logic next_lock;
  assign next_lock = lock_sync[1] & ~cal_busy_o & ~(ld_r0 & word[synbc_pkg::R0_AUTOCAL]); // RQ16

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      lock_o <= 1'b0;
      primary_supply_o <= 1'b0;
      secondary_supply_o <= 1'b0;
    end else begin
      lock_o <= next_lock;
      primary_supply_o <= rf_en & (~mute_until_locked | next_lock); // RQ10 RQ12
      secondary_supply_o <= aux_en & (~mute_until_locked | next_lock); // RQ10 RQ12
    end
  end

  // --------------------------------------------------------------------------
  // band calibration search
  // --------------------------------------------------------------------------
  synbc_pkg::synbc_cal_t cal_state;
  logic [synbc_pkg::SEARCH_W-1:0] trial;
  logic [3:0] step;
  logic [7:0] tick_cnt;
  logic [7:0] settle_ticks;

  // successive approximation over core then band, msb first: a trial bit is
  // kept while the oscillator still runs below the target
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      cal_state <= synbc_pkg::SYNBC_IDLE;
      trial <= '0;
      step <= 4'h0;
      tick_cnt <= 8'h00;
    end else if (ld_r0 && word[synbc_pkg::R0_AUTOCAL]) begin
      cal_state <= synbc_pkg::SYNBC_SETTLE; // RQ4
      trial <= {1'b1, {(synbc_pkg::SEARCH_W-1){1'b0}}}; // RQ8
      step <= 4'(synbc_pkg::SEARCH_W - 1);
      tick_cnt <= 8'h00;
    end else begin
      case (cal_state)
        synbc_pkg::SYNBC_IDLE: begin
          tick_cnt <= 8'h00;
        end
        synbc_pkg::SYNBC_SETTLE: begin
          if (tick) begin // RQ6
            if (tick_cnt + 8'h01 >= settle_ticks) begin
              cal_state <= synbc_pkg::SYNBC_JUDGE;
              tick_cnt <= 8'h00;
            end else begin
              tick_cnt <= tick_cnt + 8'h01;
            end
          end
        end
        synbc_pkg::SYNBC_JUDGE: begin
          if (high_sync[1]) begin
            trial[step] <= 1'b0; // RQ8
          end
          if (step == 4'h0) begin
            cal_state <= synbc_pkg::SYNBC_IDLE; // RQ7
          end else begin
            trial[step - 4'h1] <= 1'b1;
            step <= step - 4'h1;
            cal_state <= synbc_pkg::SYNBC_SETTLE;
          end
        end
        default: begin
          cal_state <= synbc_pkg::SYNBC_IDLE;
        end
      endcase
    end
  end

  logic next_busy;
  assign next_busy = (ld_r0 & word[synbc_pkg::R0_AUTOCAL]) |
                     (cal_state == synbc_pkg::SYNBC_SETTLE) |
                     ((cal_state == synbc_pkg::SYNBC_JUDGE) & (step != 4'h0));

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      cal_busy_o <= 1'b0;
      tune_to_ref_o <= 1'b0;
      core_o <= '0;
      band_o <= '0;
    end else begin
      cal_busy_o <= next_busy; // RQ4
      tune_to_ref_o <= next_busy; // RQ5 RQ7 RQ15
      core_o <= trial[synbc_pkg::SEARCH_W-1 -: synbc_pkg::CORE_W]; // RQ8
      band_o <= trial[synbc_pkg::BAND_W-1:0]; // RQ8
    end
  end

  // --------------------------------------------------------------------------
  // wishbone slave
  // --------------------------------------------------------------------------
  logic wb_req;
  logic [31:0] next_rdata;
  assign wb_req = wb_cyc_i & wb_stb_i & ~wb_ack_o;

  always_comb begin
    next_rdata = 32'h0000_0000;
    case (wb_adr_i)
      synbc_pkg::WB_CTRL: begin
        next_rdata = {24'h00_0000, settle_ticks};
      end
      synbc_pkg::WB_STATUS: begin
        next_rdata = {16'h0000, band_o, 2'h0, core_o, autocal, lock_o, tune_to_ref_o, cal_busy_o};
      end
      synbc_pkg::WB_INT: begin
        next_rdata = {15'h0000, prescaler_o, int_value_o};
      end
      default: begin
        next_rdata = 32'h0000_0000;
      end
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h0000_0000;
      settle_ticks <= synbc_pkg::SETTLE_RESET;
    end else begin
      wb_ack_o <= wb_req;
      wb_dat_o <= (wb_req && !wb_we_i) ? next_rdata : 32'h0000_0000;
      // zero would settle on the first tick just like one, but it is kept at one at least
      if (wb_req && wb_we_i && wb_sel_i[0] && wb_adr_i == synbc_pkg::WB_CTRL) begin
        settle_ticks <= (wb_dat_i[7:0] == 8'h00) ? 8'h01 : wb_dat_i[7:0];
      end
    end
  end
endmodule : synbc_top
`default_nettype wire

// >>> tb/synbc_top_asserts.sv
// port-level checker for the synthesizer control block
`default_nettype none
module synbc_top_asserts #(
  parameter int WORD_W = 32
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic lock_detect_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic [31:0] wb_dat_o,
  input wire logic wb_ack_o,
  input wire logic tune_to_ref_o,
  input wire logic cal_busy_o,
  input wire logic [synbc_pkg::CORE_W-1:0] core_o,
  input wire logic [synbc_pkg::BAND_W-1:0] band_o,
  input wire logic lock_o
);
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (rst_i);
  // --------------------------------------------------------------------------
  // bus handshake
  // --------------------------------------------------------------------------
  sequence s_req;
    wb_cyc_i && wb_stb_i && !wb_ack_o;
  endsequence
  sequence s_pulse;
    wb_ack_o ##1 !wb_ack_o;
  endsequence
  a_ack_one_pulse: assert property (s_req |=> s_pulse)
    else $error("ack is not one pulse after request");
  a_ack_has_cause: assert property ($rose(wb_ack_o) |-> $past(wb_cyc_i && wb_stb_i))
    else $error("ack without request");
  a_dat_idle_zero: assert property (!wb_ack_o |-> wb_dat_o == 32'h0)
    else $error("read data outside ack");
  // --------------------------------------------------------------------------
  // calibration and lock
  // --------------------------------------------------------------------------
  a_tune_with_busy: assert property (tune_to_ref_o == cal_busy_o)
    else $error("tuning switch differs from search state");
  a_no_lock_cal: assert property (cal_busy_o |-> !lock_o)
    else $error("lock shown during search");
  // index outputs follow the trial register one cycle after busy rises
  a_start_mid_trial: assert property ($rose(cal_busy_o) |=> {core_o, band_o} == 10'h200)
    else $error("search starts at wrong trial");
  // final judge lands on the index one cycle after busy falls
  a_index_idle_hold: assert property (!cal_busy_o && !$past(cal_busy_o) && !$past(cal_busy_o, 2) |->
    $stable({core_o, band_o}))
    else $error("index moves outside search");
  // three-flop path from detector to lock, one spare cycle
  a_lock_needs_det: assert property (!lock_detect_i [*4] |=> !lock_o)
    else $error("lock without detector");
endmodule : synbc_top_asserts
bind synbc_top synbc_top_asserts #(.WORD_W(WORD_W)) u_synbc_top_asserts (
  .clk_i(clk_i), .rst_i(rst_i), .lock_detect_i(lock_detect_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
  .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .tune_to_ref_o(tune_to_ref_o), .cal_busy_o(cal_busy_o),
  .core_o(core_o), .band_o(band_o), .lock_o(lock_o)
);
`default_nettype wire

// >>> tb/synbc_host.sv
// host model shifting words into the serial programming port
`default_nettype none
module synbc_host (
  output var logic sclk_o,
  output var logic sdata_o,
  output var logic load_o
);
  timeunit 1ns;
  timeprecision 100ps;
  initial begin
    sclk_o = 1'b0;
    sdata_o = 1'b0;
    load_o = 1'b0;
  end
  // --------------------------------------------------------------------------
  // one word: 32 link clocks, then strobe; clock stands still between words
  // --------------------------------------------------------------------------
  task automatic send(input logic [31:0] w);
    #1;
    for (int i = 31; i >= 0; i--) begin
      sdata_o = w[i];
      #80 sclk_o = 1'b1;
      #80 sclk_o = 1'b0;
    end
    // released line must not keep the last bit
    sdata_o = ~w[0];
    #40 load_o = 1'b1;
    #64 load_o = 1'b0;
    #40;
  endtask : send
endmodule : synbc_host
`default_nettype wire

// >>> tb/synbc_top_tb_top.sv
// self-checking bench for the synthesizer control block
`default_nettype none
module synbc_top_tb_top;
  timeunit 1ns;
  timeprecision 100ps;
  logic clk_i, rst_i, sclk, sdata, load_strobe, lock_detect_i, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o;
  logic prescaler_o, pri_o, sec_o, tune_o, busy_o, lock_o, tick_en, fb_o;
  logic ref_tick_i = 1'b0;
  logic vco_high_i = 1'b0;
  logic [7:0] tick_cnt = 8'h00;
  logic [3:0] wb_adr_i;
  logic [31:0] wb_dat_i, wb_dat_o, rdat;
  synbc_pkg::synbc_staged_t act;
  logic [15:0] int_o;
  logic [2:0] div_o;
  logic [1:0] pwr_o, core_o, apwr_o;
  logic [7:0] band_o;
  logic [9:0] target;
  int n_errors = 0;
  int checks = 0;
  synbc_top u_synbc_top (
    .clk_i(clk_i), .rst_i(rst_i), .sclk_i(sclk), .sdata_i(sdata), .load_strobe_i(load_strobe),
    .lock_detect_i(lock_detect_i), .ref_tick_i(ref_tick_i), .vco_high_i(vco_high_i), .wb_cyc_i(wb_cyc_i),
    .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(4'hf), .wb_dat_i(wb_dat_i),
    .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .active_o(act), .int_value_o(int_o), .prescaler_o(prescaler_o),
    .div_select_o(div_o), .feedback_select_o(fb_o), .out_power_o(pwr_o), .aux_power_o(apwr_o), .primary_supply_o(pri_o),
    .secondary_supply_o(sec_o), .tune_to_ref_o(tune_o), .cal_busy_o(busy_o), .core_o(core_o), .band_o(band_o),
    .lock_o(lock_o)
  );
  synbc_host u_synbc_host (.sclk_o(sclk), .sdata_o(sdata), .load_o(load_strobe));
  initial begin
    clk_i = 1'b0;
    forever #2 clk_i = ~clk_i;
  end
  // reference ticks every 8 clocks; comparator says high above the target index
  always @(posedge clk_i) begin
    tick_cnt <= tick_cnt + 8'h01;
    ref_tick_i <= tick_en & tick_cnt[2];
    vco_high_i <= {core_o, band_o} > target;
  end
  // --------------------------------------------------------------------------
  // access tasks
  // --------------------------------------------------------------------------
  task automatic check(input logic [31:0] got, input logic [31:0] exp, input string what);
    checks++;
    if (got !== exp) begin
      n_errors++;
      $display("FAIL %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask : check
  task automatic wb_xfer(input logic we, input logic [3:0] adr, input logic [31:0] wd, output logic [31:0] rd);
    int n;
    n = 0;
    @(posedge clk_i);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= we;
    wb_adr_i <= adr;
    wb_dat_i <= wd;
    do begin
      @(posedge clk_i);
      n++;
    end while (wb_ack_o !== 1'b1 && n < 64);
    rd = wb_dat_o;
    check(32'(wb_ack_o), 32'h1, "ack");
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
  endtask : wb_xfer
  task automatic rd_chk(input logic [3:0] adr, input logic [31:0] exp, input string what);
    logic [31:0] r;
    wb_xfer(1'b0, adr, 32'h0, r);
    check(r, exp, what);
  endtask : rd_chk
  task automatic print_verdict();
    $display("checks %0d errors %0d", checks, n_errors);
    if (n_errors == 0 && checks > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask : print_verdict
  initial begin
    #200us;
    n_errors++;
    $display("FAIL %0t watchdog", $time);
    print_verdict();
  end
  // --------------------------------------------------------------------------
  // tests
  // --------------------------------------------------------------------------
  initial begin
    rst_i = 1'b1;
    lock_detect_i = 1'b0;
    tick_en = 1'b1;
    target = 10'h2a5;
    wb_cyc_i = 1'b0;
    wb_stb_i = 1'b0;
    wb_we_i = 1'b0;
    wb_adr_i = 4'h0;
    wb_dat_i = 32'h0;
    repeat (16) @(posedge clk_i);
    rst_i <= 1'b0;
    rd_chk(synbc_pkg::WB_CTRL, 32'h4, "ctrl reset");
    rd_chk(synbc_pkg::WB_STATUS, 32'h0, "status reset");
    rd_chk(4'hc, 32'h0, "unmapped");
    wb_xfer(1'b1, synbc_pkg::WB_CTRL, 32'h0, rdat);
    rd_chk(synbc_pkg::WB_CTRL, 32'h1, "ctrl zero");
    u_synbc_host.send(32'h1 << synbc_pkg::R4_DBUF | 32'h5 << synbc_pkg::R4_CP_LSB | 32'h3ff << 15 |
                      32'h1 << synbc_pkg::R4_DOUBLER | 32'h4);
    u_synbc_host.send(32'habcdef << synbc_pkg::R1_FRAC_LSB | 32'h1);
    u_synbc_host.send(32'h2def << synbc_pkg::R2_FRAC_LSB | 32'h1abc << synbc_pkg::R2_MOD_LSB | 32'h2);
    u_synbc_host.send(32'h123456 << synbc_pkg::R3_PHASE_LSB | 32'h3);
    u_synbc_host.send(32'h5 << 21 | 32'h1 << 24 | 32'h3 << 4 | 32'h2 << 7 | 32'h1 << 6 | 32'h1 << 9 |
                      32'h1 << synbc_pkg::R6_MUTE | 32'h6);
    check(32'(act.main_fraction), 32'h0, "frac early");
    check(32'(act.phase), 32'h0, "phase early");
    check(32'(act.cp_current), 32'h0, "cp early");
    check(32'(div_o), 32'h0, "div early");
    check(32'(pwr_o), 32'h3, "power");
    check(32'({fb_o, apwr_o}), 32'h6, "fb aux power");
    check(32'(pri_o), 32'h0, "muted");
    @(posedge clk_i);
    lock_detect_i <= 1'b1;
    repeat (8) @(posedge clk_i);
    check(32'({pri_o, sec_o}), 32'h3, "unmuted");
    u_synbc_host.send(32'h1234 << synbc_pkg::R0_INT_LSB | 32'h1 << synbc_pkg::R0_PRESCALER);
    check(32'(act.main_fraction), 32'habcdef, "frac commit");
    check(32'({act.ref_count, act.cp_current}), 32'h3ff5, "r4 commit");
    check(32'({act.ref_doubler, act.ref_halve}), 32'h2, "ref commit");
    check(32'({act.aux_fraction, act.aux_modulus}), 32'hb7bdabc, "r2 commit");
    check(32'(act.phase), 32'h123456, "r3 commit");
    check(32'(div_o), 32'h5, "div commit");
    check(32'({busy_o, tune_o}), 32'h0, "no search");
    rd_chk(synbc_pkg::WB_INT, 32'h11234, "int");
    u_synbc_host.send(32'h7 << 21 | 32'h5);
    check(32'(div_o), 32'h5, "latch 5");
    u_synbc_host.send(32'h9 << synbc_pkg::R4_CP_LSB | 32'h4);
    u_synbc_host.send(32'h2 << 21 | 32'h1 << 9 | 32'h6);
    check(32'(div_o), 32'h2, "div now");
    check(32'({pri_o, sec_o}), 32'h1, "second only");
    check(32'(act.cp_current), 32'h5, "cp held");
    wb_xfer(1'b1, synbc_pkg::WB_CTRL, 32'h1, rdat);
    tick_en <= 1'b0;
    u_synbc_host.send(32'h1 << synbc_pkg::R0_AUTOCAL | 32'h1234 << synbc_pkg::R0_INT_LSB);
    repeat (64) @(posedge clk_i);
    check(32'({busy_o, tune_o, lock_o}), 32'h6, "search runs");
    check(32'({core_o, band_o}), 32'h200, "no tick");
    check(32'(act.cp_current), 32'h9, "cp commit");
    tick_en <= 1'b1;
    for (int i = 0; i < 3000 && busy_o !== 1'b0; i++) @(posedge clk_i);
    // last judged bit reaches the index outputs one edge after busy falls
    @(posedge clk_i);
    @(negedge clk_i);
    check(32'({core_o, band_o}), 32'h2a5, "result");
    check(32'(tune_o), 32'h0, "reconnect");
    repeat (8) @(posedge clk_i);
    rd_chk(synbc_pkg::WB_STATUS, 32'ha52c, "status");
    print_verdict();
  end
endmodule : synbc_top_tb_top
`default_nettype wire
